// ### rtl/pic_pkg.sv
// Package for the priority interrupt controller: register selects, reset values, field layout and carrier types
package pic_pkg;

   // ************************************************************
   // Register select codes
   // ************************************************************
   localparam logic [2:0]  SEL_PENDING_LOW    = 3'h0;
   localparam logic [2:0]  SEL_MASK_LOW       = 3'h1;
   localparam logic [2:0]  SEL_PRIO_LOW       = 3'h2;
   localparam logic [2:0]  SEL_ID_A           = 3'h3;
   localparam logic [2:0]  SEL_PENDING_HIGH   = 3'h4;
   localparam logic [2:0]  SEL_MASK_HIGH      = 3'h5;
   localparam logic [2:0]  SEL_PRIO_HIGH      = 3'h6;
   localparam logic [2:0]  SEL_ID_B           = 3'h7;

   // ************************************************************
   // Reset values and the fixed priority order of sources 16-23
   // ************************************************************
   localparam logic [31:0] PENDING_RESET      = 32'h0000_0000;
   localparam logic [15:0] MASK_RESET         = 16'h0000;
   localparam logic [12:0] PRIO_LOW_RESET     = 13'h0010;
   localparam logic [7:0]  PRIO_HIGH_RESET    = 8'h10;
   localparam logic [7:0]  PRIO_FIXED_ORDER   = 8'h10;
   localparam logic [15:0] READ_RESET         = 16'h0000;

   // ************************************************************
   // Field layout
   // ************************************************************
   localparam int unsigned PRIO_DIR_BIT       = 4;
   localparam int unsigned PRIO_SWAP_BIT      = 8;
   localparam int unsigned ID_FIELD_LSB       = 9;
   localparam int unsigned ID_FIELD_MSB       = 13;
   localparam logic [7:0]  CLEAR_ALL_UPPER    = 8'h40;
   localparam logic [7:0]  CLEAR_ALL_LOWER    = 8'h00;
   localparam logic [4:0]  BASE_BYTE_A        = 5'h00;
   localparam logic [4:0]  BASE_BYTE_B        = 5'h08;
   localparam logic [4:0]  BASE_BYTE_C        = 5'h10;
   localparam logic [4:0]  BASE_BYTE_D        = 5'h18;

   // ************************************************************
   // Carrier types
   // ************************************************************
   typedef struct packed {
      logic       valid;
      logic [4:0] idx;
   } pic_win_type;

   typedef struct packed {
      logic [31:0] pending;
      logic [31:0] mask;
      logic [12:0] prio_low;
      logic [7:0]  prio_high;
      logic [31:0] src_prev;
      logic        wr_prev_n;
      logic        rd_prev_n;
      logic        ack_prev_n;
      pic_win_type winner;
      logic [15:0] read_bus;
      logic        clr_pulse_n;
      logic        resume;
   } pic_state_type;

endpackage

// ### rtl/pic_controller.sv
// Priority interrupt controller: 32 edge sources, masking, programmable priority (sources 16-23 fixed order) and winner ID register
`timescale 1ns/1ps

module pic_controller
   import pic_pkg::*;
(
   // Clock, reset, enable
   input  wire logic        i_clk,
   input  wire logic        i_nrst,
   input  wire logic        i_ce,
   // Register port
   input  wire logic [2:0]  i_reg_select,
   input  wire logic        i_upper_lane_strobe,
   input  wire logic        i_lower_lane_strobe,
   input  wire logic        i_write_strobe_n,
   input  wire logic        i_read_strobe_n,
   input  wire logic [15:0] i_write_bus,
   output logic      [15:0] o_read_bus,
   // Core interrupt handshake
   input  wire logic        i_core_ack_n,
   output logic             o_core_irq_n,
   output logic      [4:0]  o_winner_index,
   output logic             o_id_clear_pulse_n,
   output logic             o_resume_request,
   // Sources
   input  wire logic [31:0] i_source_requests
);

   // ************************************************************
   // Helper functions
   // ************************************************************
   // Scan from lowest to highest rank so the top-ranked request is written last
   function automatic pic_win_type pick_byte(input logic [7:0] req,
                                             input logic [7:0] cfg,
                                             input logic [4:0] base);
      pic_win_type w;
      logic [2:0]  pos;
      logic [2:0]  k3;
      w.valid = 1'b0;
      w.idx   = base;
      for (int k = 7; k >= 0; k--) begin
         k3  = 3'(k);
         pos = cfg[PRIO_DIR_BIT] ? 3'(cfg[2:0] + k3) : 3'(cfg[2:0] - k3);
         if (req[pos]) begin
            w.valid = 1'b1;
            w.idx   = base | {2'b00, pos};
         end
      end
      return w;
   endfunction

   function automatic logic [15:0] lane_mask(input logic up, input logic lo);
      return {{8{up}}, {8{lo}}};
   endfunction

   function automatic logic [15:0] merge_lanes(input logic [15:0] old_v,
                                               input logic [15:0] data,
                                               input logic [15:0] lanes);
      return (old_v & ~lanes) | (data & lanes);
   endfunction

   // ************************************************************
   // State
   // ************************************************************
   pic_state_type st;
   pic_state_type next_st;
   logic          irq_n;

   pic_win_type   win_a;
   pic_win_type   win_b;
   pic_win_type   win_c;
   pic_win_type   win_d;
   pic_win_type   cur;
   logic [31:0]   live;
   logic [31:0]   edge_vec;
   logic [15:0]   lanes;
   logic          wr_req;
   logic          rd_req;
   logic          id_sel;
   logic          id_rd;
   logic          id_wr;
   logic          clr_all;
   logic          clr_one;
   logic [4:0]    clr_idx;
   logic [15:0]   rd_word;

   // ************************************************************
   // Arbitration
   // ************************************************************
   assign live     = st.pending & st.mask;
   assign edge_vec = i_source_requests & ~st.src_prev;

   always_comb begin
      win_a = pick_byte(live[7:0], st.prio_low[7:0], BASE_BYTE_A);
      win_b = pick_byte(live[15:8], st.prio_low[7:0], BASE_BYTE_B);
      win_c = pick_byte(live[23:16], PRIO_FIXED_ORDER, BASE_BYTE_C);
      win_d = pick_byte(live[31:24], st.prio_high, BASE_BYTE_D);
      // Subgroup swap decides which low byte is consulted first
      if (st.prio_low[PRIO_SWAP_BIT]) begin
         cur = win_b.valid ? win_b : win_a;
      end else begin
         cur = win_a.valid ? win_a : win_b;
      end
      // Low half always ahead of the high half
      if (!cur.valid) begin
         cur = win_c.valid ? win_c : win_d;
      end
      // An empty scan reads as index zero, not as the last group's base
      if (!cur.valid) begin
         cur.idx = 5'h00;
      end
   end

   // ************************************************************
   // Register port decode
   // ************************************************************
   // Act once per strobe, on its first low sample, so a long strobe is one access
   assign wr_req  = !i_write_strobe_n && st.wr_prev_n && (i_upper_lane_strobe || i_lower_lane_strobe);
   assign rd_req  = !i_read_strobe_n && st.rd_prev_n && (i_upper_lane_strobe || i_lower_lane_strobe);
   assign lanes   = lane_mask(i_upper_lane_strobe, i_lower_lane_strobe);
   assign id_sel  = (i_reg_select == SEL_ID_A) || (i_reg_select == SEL_ID_B);
   assign id_rd   = rd_req && id_sel;
   assign id_wr   = wr_req && id_sel;
   assign clr_all = id_wr && i_upper_lane_strobe && (i_write_bus[15:8] == CLEAR_ALL_UPPER)
                    && (!i_lower_lane_strobe || (i_write_bus[7:0] == CLEAR_ALL_LOWER));
   assign clr_one = id_wr && i_upper_lane_strobe && !clr_all;
   assign clr_idx = i_write_bus[ID_FIELD_MSB:ID_FIELD_LSB];

   always_comb begin
      unique case (i_reg_select)
         SEL_PENDING_LOW:  rd_word = st.pending[15:0];
         SEL_MASK_LOW:     rd_word = st.mask[15:0];
         SEL_PRIO_LOW:     rd_word = {3'h0, st.prio_low};
         SEL_PENDING_HIGH: rd_word = st.pending[31:16];
         SEL_MASK_HIGH:    rd_word = st.mask[31:16];
         SEL_PRIO_HIGH:    rd_word = {8'h00, st.prio_high};
         SEL_ID_A,
         SEL_ID_B:         rd_word = {2'b00, st.winner.idx, 9'h000};
      endcase
   end

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      next_st            = st;
      next_st.src_prev   = i_source_requests;
      next_st.wr_prev_n  = i_write_strobe_n;
      next_st.rd_prev_n  = i_read_strobe_n;
      next_st.ack_prev_n = i_core_ack_n;

      // Winner still loads on the first edge that samples the acknowledge, then stays frozen so the ISR sees a stable ID
      if (i_core_ack_n || st.ack_prev_n) begin
         next_st.winner = cur;
      end

      // Clears first; sets afterwards so that a fresh edge survives a clear
      if (clr_all) begin
         next_st.pending = PENDING_RESET;
      end
      if (clr_one) begin
         next_st.pending[clr_idx] = 1'b0;
      end
      if (id_rd && st.winner.valid) begin
         next_st.pending[st.winner.idx] = 1'b0;
      end
      next_st.pending = next_st.pending | edge_vec;

      if (wr_req) begin
         unique case (i_reg_select)
            // Writes only ever add pending bits
            SEL_PENDING_LOW:  next_st.pending[15:0]  = next_st.pending[15:0] | (i_write_bus & lanes);
            SEL_PENDING_HIGH: next_st.pending[31:16] = next_st.pending[31:16] | (i_write_bus & lanes);
            SEL_MASK_LOW:     next_st.mask[15:0]     = merge_lanes(st.mask[15:0], i_write_bus, lanes);
            SEL_MASK_HIGH:    next_st.mask[31:16]    = merge_lanes(st.mask[31:16], i_write_bus, lanes);
            SEL_PRIO_LOW:     next_st.prio_low       = 13'(merge_lanes({3'h0, st.prio_low}, i_write_bus, lanes));
            SEL_PRIO_HIGH:    next_st.prio_high      = 8'(merge_lanes({8'h00, st.prio_high}, i_write_bus, lanes));
            SEL_ID_A,
            SEL_ID_B:         next_st.winner         = next_st.winner;
         endcase
      end

      if (rd_req) begin
         next_st.read_bus = rd_word & lanes;
      end

      next_st.clr_pulse_n = !(id_rd || clr_all);
      next_st.resume      = |next_st.pending;
   end

   // ************************************************************
   // Registers
   // ************************************************************
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st.pending     <= PENDING_RESET;
         st.mask        <= {MASK_RESET, MASK_RESET};
         st.prio_low    <= PRIO_LOW_RESET;
         st.prio_high   <= PRIO_HIGH_RESET;
         st.src_prev    <= PENDING_RESET;
         st.wr_prev_n   <= 1'b1;
         st.rd_prev_n   <= 1'b1;
         st.ack_prev_n  <= 1'b1;
         st.winner      <= '0;
         st.read_bus    <= READ_RESET;
         st.clr_pulse_n <= 1'b1;
         st.resume      <= 1'b0;
      end else if (i_ce) begin
         st <= next_st;
      end
   end

   // Falling-edge stage gives the core a half cycle of setup on the request
   always_ff @(negedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         irq_n <= 1'b1;
      end else if (i_ce) begin
         irq_n <= !(|live);
      end
   end

   assign o_core_irq_n       = irq_n;
   assign o_winner_index     = st.winner.idx;
   assign o_read_bus         = st.read_bus;
   assign o_id_clear_pulse_n = st.clr_pulse_n;
   assign o_resume_request   = st.resume;

   // ************************************************************
   // Assertions
   // ************************************************************
   logic [31:0] win_onehot;
   assign win_onehot = 32'h0000_0001 << st.winner.idx;

   property p_edge_sets;
      @(posedge i_clk) disable iff (!i_nrst)
      i_ce && (edge_vec != 32'h0000_0000) |=> ((st.pending & $past(edge_vec)) == $past(edge_vec));
   endproperty
   a_edge_sets: assert property (p_edge_sets) else $error("source edge did not set pending");

   property p_no_clear_without_id;
      @(posedge i_clk) disable iff (!i_nrst)
      i_ce && !id_rd && !id_wr |=> ((st.pending & $past(st.pending)) == $past(st.pending));
   endproperty
   a_no_clear_without_id: assert property (p_no_clear_without_id) else $error("pending bit lost");

   property p_read_clears;
      @(posedge i_clk) disable iff (!i_nrst)
      i_ce && id_rd && st.winner.valid && ((edge_vec & win_onehot) == 32'h0000_0000)
      |=> ((st.pending & $past(win_onehot)) == 32'h0000_0000);
   endproperty
   a_read_clears: assert property (p_read_clears) else $error("ID read left winner pending");

   property p_winner_unmasked;
      @(posedge i_clk) disable iff (!i_nrst)
      cur.valid |-> live[cur.idx];
   endproperty
   a_winner_unmasked: assert property (p_winner_unmasked) else $error("masked source won");

   property p_low_half_first;
      @(posedge i_clk) disable iff (!i_nrst)
      (live[15:0] != 16'h0000) |-> (cur.valid && !cur.idx[4]);
   endproperty
   a_low_half_first: assert property (p_low_half_first) else $error("high half beat low half");

   property p_clear_all;
      @(posedge i_clk) disable iff (!i_nrst)
      i_ce && clr_all |=> ((st.pending & ~$past(edge_vec)) == 32'h0000_0000);
   endproperty
   a_clear_all: assert property (p_clear_all) else $error("clear-all left pending bits");

   property p_clear_pulse;
      @(posedge i_clk) disable iff (!i_nrst)
      i_ce |=> (o_id_clear_pulse_n == !($past(id_rd) || $past(clr_all)));
   endproperty
   a_clear_pulse: assert property (p_clear_pulse) else $error("clear pulse wrong");

   property p_irq_level;
      @(negedge i_clk) disable iff (!i_nrst)
      i_ce |=> (o_core_irq_n == !$past(|live));
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("interrupt output wrong");

   property p_resume;
      @(posedge i_clk) disable iff (!i_nrst)
      o_resume_request == (|st.pending);
   endproperty
   a_resume: assert property (p_resume) else $error("resume output wrong");

   property p_id_value;
      @(posedge i_clk) disable iff (!i_nrst)
      i_ce && id_rd && i_upper_lane_strobe |=> (o_read_bus[13:9] == $past(st.winner.idx));
   endproperty
   a_id_value: assert property (p_id_value) else $error("ID read value wrong");

   property p_mask_reset;
      @(posedge i_clk)
      $rose(i_nrst) |-> (st.mask == 32'h0000_0000) && (st.prio_low == PRIO_LOW_RESET);
   endproperty
   a_mask_reset: assert property (p_mask_reset) else $error("reset values wrong");

   property p_one_winner;
      @(posedge i_clk) disable iff (!i_nrst)
      (live != 32'h0000_0000) |-> cur.valid;
   endproperty
   a_one_winner: assert property (p_one_winner) else $error("unmasked pending without a winner");

   property p_read_lanes;
      @(posedge i_clk) disable iff (!i_nrst)
      i_ce && rd_req && !i_upper_lane_strobe |=> (o_read_bus[15:8] == 8'h00);
   endproperty
   a_read_lanes: assert property (p_read_lanes) else $error("disabled read lane not zero");

   // The ISR must see the same ID for the whole acknowledge
   property p_winner_frozen;
      @(posedge i_clk) disable iff (!i_nrst)
      i_ce && !i_core_ack_n && !st.ack_prev_n |=> $stable(st.winner);
   endproperty
   a_winner_frozen: assert property (p_winner_frozen) else $error("winner moved during acknowledge");

   property p_id_write_clears;
      @(posedge i_clk) disable iff (!i_nrst)
      i_ce && clr_one && !edge_vec[clr_idx] |=> !st.pending[$past(clr_idx)];
   endproperty
   a_id_write_clears: assert property (p_id_write_clears) else $error("ID write left bit pending");

   property p_pending_write_sets;
      @(posedge i_clk) disable iff (!i_nrst)
      i_ce && wr_req && (i_reg_select == SEL_PENDING_LOW)
      |=> ((st.pending[15:0] & $past(i_write_bus & lanes)) == $past(i_write_bus & lanes));
   endproperty
   a_pending_write_sets: assert property (p_pending_write_sets) else $error("pending write lost a one");

   c_read_clear: cover property (@(posedge i_clk) disable iff (!i_nrst) id_rd && st.winner.valid);
   c_clear_all: cover property (@(posedge i_clk) disable iff (!i_nrst) clr_all);
   c_unmask_raise: cover property (@(posedge i_clk) disable iff (!i_nrst)
      (st.pending != 32'h0000_0000) && (live == 32'h0000_0000) ##1 (live != 32'h0000_0000));
   c_swap_order: cover property (@(posedge i_clk) disable iff (!i_nrst)
      st.prio_low[PRIO_SWAP_BIT] && win_a.valid && win_b.valid);
   c_acked_read: cover property (@(posedge i_clk) disable iff (!i_nrst) !i_core_ack_n && id_rd);

endmodule

// ### tb/pic_core_model.sv
// Core-side partner: register accesses and interrupt acknowledge
`timescale 1ns/1ps

module pic_core_model
   import pic_pkg::*;
(
   // Clock and answers
   input  wire logic        i_clk,
   input  wire logic [15:0] i_read_bus,
   input  wire logic        i_id_clear_pulse_n,
   // Register port
   output logic      [2:0]  o_reg_select,
   output logic             o_upper_lane_strobe,
   output logic             o_lower_lane_strobe,
   output logic             o_write_strobe_n,
   output logic             o_read_strobe_n,
   output logic      [15:0] o_write_bus,
   output logic             o_core_ack_n
);
   logic last_pulse_n;

   initial begin
      o_reg_select        = 3'h0;
      {o_upper_lane_strobe, o_lower_lane_strobe} = 2'b00;
      o_write_strobe_n    = 1'b1;
      o_read_strobe_n     = 1'b1;
      o_write_bus         = 16'h0000;
      o_core_ack_n        = 1'b1;
      last_pulse_n        = 1'b1;
   end

   // One access; strobe low over one sampled edge, high again before the next
   task automatic access(input logic wr, input logic [2:0] sel, input logic [1:0] lanes,
                         input logic [15:0] data, output logic [15:0] rd);
      @(posedge i_clk);
      #1;
      o_reg_select = sel;
      {o_upper_lane_strobe, o_lower_lane_strobe} = lanes;
      o_write_bus  = data;
      if (wr) o_write_strobe_n = 1'b0;
      else o_read_strobe_n = 1'b0;
      @(posedge i_clk);
      #1;
      rd           = i_read_bus;
      last_pulse_n = i_id_clear_pulse_n;
      o_write_strobe_n = 1'b1;
      o_read_strobe_n  = 1'b1;
      // Released data lines must not keep looking valid
      o_write_bus  = ~data;
      {o_upper_lane_strobe, o_lower_lane_strobe} = 2'b00;
   endtask

   // Interrupt service: acknowledge, wait a while, read the ID, release
   task automatic service(input int dly, input logic [2:0] sel, output logic [15:0] id);
      @(posedge i_clk);
      #1;
      o_core_ack_n = 1'b0;
      repeat (dly) @(posedge i_clk);
      access(1'b0, sel, 2'b11, 16'h0000, id);
      o_core_ack_n = 1'b1;
   endtask
endmodule

// ### tb/tb_top.sv
// Self-checking bench of the priority interrupt controller
`timescale 1ns/1ps

module tb_top;
   import pic_pkg::*;
   logic i_clk, i_nrst, irq_n, pls_n, res;
   logic [31:0] src, pend, msk, v;
   logic [15:0] rbus, rd;
   logic [4:0]  widx;
   logic [12:0] pl;
   logic [7:0]  ph;
   logic [5:0]  w;
   int n_fail, num_checks, cyc;
   logic [15:0] rst_val [7] = '{16'h0, 16'h0, 16'h0010, 16'h0, 16'h0, 16'h0, 16'h0010};

   // ************************************************************
   // Design and core partner
   // ************************************************************
   wire [2:0] sel;
   wire up, lo, wr_n, rd_n, ack_n;
   wire [15:0] wbus;
   pic_controller i_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(1'b1), .i_reg_select(sel),
      .i_upper_lane_strobe(up), .i_lower_lane_strobe(lo), .i_write_strobe_n(wr_n),
      .i_read_strobe_n(rd_n), .i_write_bus(wbus), .o_read_bus(rbus), .i_core_ack_n(ack_n),
      .o_core_irq_n(irq_n), .o_winner_index(widx), .o_id_clear_pulse_n(pls_n),
      .o_resume_request(res), .i_source_requests(src));
   pic_core_model i_core (.i_clk(i_clk), .i_read_bus(rbus), .i_id_clear_pulse_n(pls_n),
      .o_reg_select(sel), .o_upper_lane_strobe(up), .o_lower_lane_strobe(lo),
      .o_write_strobe_n(wr_n), .o_read_strobe_n(rd_n), .o_write_bus(wbus), .o_core_ack_n(ack_n));

   // ************************************************************
   // Expectations and helpers
   // ************************************************************
   function automatic logic [3:0] pick(input logic [7:0] b, input logic [7:0] cfg);
      logic [2:0] pos;
      for (int k = 0; k < 8; k++) begin
         pos = cfg[4] ? cfg[2:0] + 3'(k) : cfg[2:0] - 3'(k);
         if (b[pos]) return {1'b1, pos};
      end
      return 4'h0;
   endfunction

   // Upper low byte first when swapped; 16-23 fixed, then 24-31
   function automatic logic [5:0] exp_win(input logic [31:0] c);
      logic [3:0] r;
      logic [1:0] g;
      for (int i = 0; i < 4; i++) begin
         g = (i < 2 && pl[8]) ? 2'(1 - i) : 2'(i);
         r = pick(c[g*8 +: 8], (i == 3) ? ph : (i == 2) ? PRIO_FIXED_ORDER : pl[7:0]);
         if (r[3]) return {1'b1, g, r[2:0]};
      end
      return 6'h00;
   endfunction

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wr(input logic [2:0] s, input logic [1:0] l, input logic [15:0] d);
      logic [15:0] t;
      i_core.access(1'b1, s, l, d, t);
   endtask

   task automatic rdc(input string n, input logic [2:0] s, input logic [1:0] l, input logic [15:0] e);
      i_core.access(1'b0, s, l, 16'h0000, rd);
      chk(n, {16'h0, e}, {16'h0, rd});
   endtask

   task automatic pulse(input logic [31:0] p);
      @(posedge i_clk);
      #1 src = p;
      @(posedge i_clk);
      #1 src = 32'h0;
      pend |= p;
   endtask

   task automatic serve_all();
      for (int n = 0; n < 40; n++) begin
         @(posedge i_clk);
         @(negedge i_clk);
         #1 w = exp_win(pend & msk);
         if (!w[5]) break;
         chk("irq_n", 32'h0, {31'h0, irq_n});
         chk("winner", {27'h0, w[4:0]}, {27'h0, widx});
         i_core.service(1 + $urandom_range(3), $urandom_range(1) ? SEL_ID_B : SEL_ID_A, rd);
         chk("id", {18'h0, w[4:0], 9'h0}, {16'h0, rd});
         chk("clr_pulse", 32'h0, {31'h0, i_core.last_pulse_n});
         pend[w[4:0]] = 1'b0;
      end
      chk("irq_idle", 32'h1, {31'h0, irq_n});
      chk("resume", {31'h0, |pend}, {31'h0, res});
   endtask

   task automatic print_verdict();
      $display("checks=%0d fails=%0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // ************************************************************
   // Clock, timeout, sequence
   // ************************************************************
   initial begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end

   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 40000) begin
         n_fail++;
         print_verdict();
      end
   end

   initial begin
      i_nrst = 1'b0;
      src = 32'h0;
      pend = 32'h0;
      msk = 32'h0;
      pl = PRIO_LOW_RESET;
      ph = PRIO_HIGH_RESET;
      void'($urandom(32'hed064568));
      repeat (5) @(posedge i_clk);
      #1 i_nrst = 1'b1;
      for (int i = 0; i < 7; i++) rdc("reset_reg", 3'(i), 2'b11, rst_val[i]);
      chk("irq_rst", 32'h1, {31'h0, irq_n});
      // Masked pending, then unmasked without a new edge
      pulse(32'h0000_0002);
      chk("resume_masked", 32'h1, {31'h0, res});
      repeat (2) @(posedge i_clk);
      chk("irq_masked", 32'h1, {31'h0, irq_n});
      fork
         wr(SEL_MASK_LOW, 2'b11, 16'h0002);
         begin
            repeat (2) @(posedge i_clk);
            #1 chk("irq_at_rise", 32'h1, {31'h0, irq_n});
            #4 chk("irq_at_fall", 32'h0, {31'h0, irq_n});
         end
      join
      msk = 32'h0000_0002;
      serve_all();
      // Pending writes, lanes and ID-register clears
      pulse(32'h0000_0008);
      wr(SEL_PENDING_LOW, 2'b11, 16'h0000);
      rdc("pend_zero_wr", SEL_PENDING_LOW, 2'b11, 16'h0008);
      wr(SEL_PENDING_HIGH, 2'b10, 16'h0101);
      rdc("pend_lane_lo", SEL_PENDING_HIGH, 2'b01, 16'h0000);
      rdc("pend_lane_hi", SEL_PENDING_HIGH, 2'b10, 16'h0100);
      wr(SEL_ID_B, 2'b11, 16'h3000);
      rdc("id_wr_clear", SEL_PENDING_HIGH, 2'b11, 16'h0000);
      wr(SEL_PRIO_LOW, 2'b11, 16'hffff);
      rdc("prio_low_w", SEL_PRIO_LOW, 2'b11, 16'h1fff);
      wr(SEL_PRIO_HIGH, 2'b11, 16'hffff);
      rdc("prio_high_w", SEL_PRIO_HIGH, 2'b11, 16'h00ff);
      fork
         wr(SEL_ID_A, 2'b11, 16'h0600);
         begin
            @(posedge i_clk);
            #1 src = 32'h0000_0008;
            @(posedge i_clk);
            #1 src = 32'h0;
         end
      join
      rdc("edge_beats_clr", SEL_PENDING_LOW, 2'b11, 16'h0008);
      wr(SEL_ID_B, 2'b11, 16'h4000);
      chk("clr_all_pulse", 32'h0, {31'h0, i_core.last_pulse_n});
      rdc("clr_all_lo", SEL_PENDING_LOW, 2'b11, 16'h0000);
      chk("resume_clr", 32'h0, {31'h0, res});
      // Random priority, mask and source mixes
      for (int it = 0; it < 30; it++) begin
         v = $urandom;
         pl = v[12:0];
         v = $urandom;
         ph = v[7:0];
         msk = $urandom;
         wr(SEL_ID_B, 2'b11, 16'h4000);
         pend = 32'h0;
         wr(SEL_PRIO_LOW, 2'b11, {3'h0, pl});
         wr(SEL_PRIO_HIGH, 2'b11, {8'h0, ph});
         wr(SEL_MASK_LOW, 2'b11, msk[15:0]);
         wr(SEL_MASK_HIGH, 2'b11, msk[31:16]);
         v = $urandom;
         if (v[0]) v[31:24] = 8'h00;
         else v[23:16] = 8'h00;
         pulse(v);
         serve_all();
      end
      print_verdict();
   end
endmodule
